// file: core/dcm_defs.svh
// Constants for the dual counter/timer measurement block.
// Assumes inclusion by the design modules; the package does not include it.
// Behaviour
// - Two independent channels, 32-bit counts each
// - Counting, measuring and pulse output modes
// - Gated counting: rising edges while gate active
// - Software gate: count edges once started
// - Up/down: gate high adds, low subtracts
// - Frequency: count edges during known gate pulse
// - Pulse width active level software selectable
// - Edge-to-edge: count from start to stop edge
// - Continuous: counts between consecutive start edges
`ifndef DCM_DEFS_SVH
`define DCM_DEFS_SVH
`define DCM_CNT_W 32
`define DCM_CH_CTRL0 8'h00
`define DCM_CH_CTRL1 8'h04
`define DCM_CH_LOAD0 8'h08
`define DCM_CH_LOAD1 8'h0C
`define DCM_CH_CNT0 8'h10
`define DCM_CH_CNT1 8'h14
`define DCM_CH_RES0 8'h18
`define DCM_CH_RES1 8'h1C
`define DCM_CH_HI0 8'h20
`define DCM_CH_HI1 8'h24
`define DCM_REF_DIV 16'h0001
`define DCM_CTRL_EN 0
`define DCM_CTRL_MODE_LO 1
`define DCM_CTRL_GPOL 5
`define DCM_CTRL_START_SRC 6
`define DCM_CTRL_STOP_SRC 8
`define DCM_CTRL_OPOL 10
`endif

// file: core/dcm_pkg.sv
// Types for the dual counter/timer measurement block.
// Assumes the constants header sits alongside.
package dcm_pkg;
	// Operating modes, four bits in the control word
	typedef enum logic [3:0] {
		DCM_IDLE = 4'h0,
		DCM_EVT_GATE = 4'h1,
		DCM_EVT_SW = 4'h2,
		DCM_UPDN = 4'h3,
		DCM_FREQ = 4'h4,
		DCM_PERIOD = 4'h5,
		DCM_E2E = 4'h6,
		DCM_E2E_CONT = 4'h7,
		DCM_RATE = 4'h8,
		DCM_ONESHOT = 4'h9,
		DCM_REP_ONESHOT = 4'hA
	} dcm_mode_t;
	// Channel phase, Gray coded along wait, run, done
	typedef enum logic [1:0] {
		DCM_PH_STOP = 2'b00,
		DCM_PH_WAIT = 2'b01,
		DCM_PH_RUN = 2'b11,
		DCM_PH_DONE = 2'b10
	} dcm_phase_t;
endpackage

// file: core/dcm_channel.sv
// One counter/timer channel: edge detection, counting and pulse output.
// Assumes synchronous inputs and a one-cycle reference tick.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dcm_defs.svh"
module dcm_channel
	import dcm_pkg::*;
#(
	parameter int CW = `DCM_CNT_W
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire dcm_mode_t mode_i,
	input wire logic gate_pol_i,
	input wire logic [1:0] start_src_i,
	input wire logic [1:0] stop_src_i,
	input wire logic out_pol_i,
	input wire logic [CW-1:0] load_i,
	input wire logic ref_tick_i,
	input wire logic count_in_i,
	input wire logic gate_in_i,
	output logic [CW-1:0] count_o,
	output logic [CW-1:0] result_o,
	output logic [CW-1:0] active_o,
	output logic done_o,
	output logic pulse_o
);
	logic clk_d_r, gate_d_r, en_d_r;
	logic [CW-1:0] cnt_r, cnt_nxt, res_r, res_nxt, act_r, act_nxt;
	dcm_phase_t ph_r, ph_nxt;
	logic out_r, out_nxt;
	logic clk_rise, clk_fall, gate_rise, gate_fall, gate_act, start_ev, stop_ev, go;
	logic [3:0] edges;

	// Edge detection on the external inputs
	assign clk_rise = count_in_i & ~clk_d_r;
	assign clk_fall = ~count_in_i & clk_d_r;
	assign gate_rise = gate_in_i & ~gate_d_r;
	assign gate_fall = ~gate_in_i & gate_d_r;
	assign gate_act = (gate_in_i == gate_pol_i);
	assign edges = {gate_fall, gate_rise, clk_fall, clk_rise};
	assign start_ev = edges[start_src_i];
	assign stop_ev = edges[stop_src_i];
	assign go = en_i & ~en_d_r;

	// Next state of counters and phase
	always_comb
	begin
		cnt_nxt = cnt_r;
		res_nxt = res_r;
		act_nxt = act_r;
		ph_nxt = ph_r;
		out_nxt = out_r;
		if (!en_i)
		begin
			ph_nxt = DCM_PH_STOP;
			out_nxt = 1'b0;
		end
		else if (go)
		begin
			cnt_nxt = '0;
			act_nxt = '0;
			out_nxt = 1'b0;
			case (mode_i)
				DCM_EVT_SW, DCM_UPDN, DCM_RATE, DCM_ONESHOT, DCM_REP_ONESHOT:
					ph_nxt = DCM_PH_RUN;
				DCM_IDLE:
					ph_nxt = DCM_PH_STOP;
				default:
					ph_nxt = DCM_PH_WAIT;
			endcase
		end
		else
		begin
			case (mode_i)
				DCM_EVT_GATE:
					if (clk_rise && gate_act)
						cnt_nxt = cnt_r + 1'b1;
				DCM_EVT_SW:
					if (clk_rise)
						cnt_nxt = cnt_r + 1'b1;
				DCM_UPDN:
					if (clk_rise)
						cnt_nxt = gate_in_i ? cnt_r + 1'b1 : cnt_r - 1'b1;
				DCM_FREQ:
				begin
					// Count edges through one active gate pulse
					if (ph_r == DCM_PH_WAIT && gate_act && (gate_rise || gate_fall))
						ph_nxt = DCM_PH_RUN;
					else if (ph_r == DCM_PH_RUN && !gate_act)
					begin
						res_nxt = cnt_r;
						ph_nxt = DCM_PH_DONE;
					end
					else if (ph_r == DCM_PH_RUN && clk_rise)
						cnt_nxt = cnt_r + 1'b1;
				end
				DCM_PERIOD:
				begin
					// Period between active-going gate edges; active time alongside
					if (ph_r == DCM_PH_WAIT && gate_act && (gate_rise || gate_fall))
						ph_nxt = DCM_PH_RUN;
					else if (ph_r == DCM_PH_RUN)
					begin
						// Closing edge's tick counts, so a full period is reported
						if (ref_tick_i)
						begin
							cnt_nxt = cnt_r + 1'b1;
							if (gate_act)
								act_nxt = act_r + 1'b1;
						end
						if (gate_act && (gate_rise || gate_fall))
						begin
							res_nxt = cnt_nxt;
							ph_nxt = DCM_PH_DONE;
						end
					end
				end
				DCM_E2E:
					if (ph_r == DCM_PH_WAIT && start_ev)
						ph_nxt = DCM_PH_RUN;
					else if (ph_r == DCM_PH_RUN)
					begin
						// Stop edge's tick counts, as for the period
						if (ref_tick_i)
							cnt_nxt = cnt_r + 1'b1;
						if (stop_ev)
						begin
							res_nxt = cnt_nxt;
							ph_nxt = DCM_PH_DONE;
						end
					end
				DCM_E2E_CONT:
					if (start_ev)
					begin
						if (ph_r != DCM_PH_WAIT)
							res_nxt = ref_tick_i ? cnt_r + 1'b1 : cnt_r;
						cnt_nxt = '0;
						ph_nxt = DCM_PH_RUN;
					end
					else if (ph_r != DCM_PH_WAIT && ref_tick_i)
						cnt_nxt = cnt_r + 1'b1;
				DCM_RATE, DCM_ONESHOT, DCM_REP_ONESHOT:
				begin
					// Pulse output: load_i sets the half period or pulse length
					if (mode_i != DCM_RATE && ph_r == DCM_PH_RUN && !out_r && gate_act
						&& (gate_rise || gate_fall))
						out_nxt = 1'b1;
					else if (mode_i == DCM_RATE && ph_r == DCM_PH_RUN && ref_tick_i)
					begin
						if (cnt_r >= load_i)
						begin
							cnt_nxt = '0;
							out_nxt = ~out_r;
						end
						else
							cnt_nxt = cnt_r + 1'b1;
					end
					else if (out_r && ref_tick_i)
					begin
						if (cnt_r >= load_i)
						begin
							cnt_nxt = '0;
							out_nxt = 1'b0;
							if (mode_i == DCM_ONESHOT)
								ph_nxt = DCM_PH_DONE;
						end
						else
							cnt_nxt = cnt_r + 1'b1;
					end
				end
				default:
					ph_nxt = DCM_PH_STOP;
			endcase
		end
	end

	// Register stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clk_d_r <= 1'b0;
			gate_d_r <= 1'b0;
			en_d_r <= 1'b0;
			cnt_r <= '0;
			res_r <= '0;
			act_r <= '0;
			ph_r <= DCM_PH_STOP;
			out_r <= 1'b0;
		end
		else
		begin
			clk_d_r <= count_in_i;
			gate_d_r <= gate_in_i;
			en_d_r <= en_i;
			cnt_r <= cnt_nxt;
			res_r <= res_nxt;
			act_r <= act_nxt;
			ph_r <= ph_nxt;
			out_r <= out_nxt;
		end
	end

	assign count_o = cnt_r;
	assign result_o = res_r;
	assign active_o = act_r;
	assign done_o = (ph_r == DCM_PH_DONE);
	assign pulse_o = out_r ^ out_pol_i;
endmodule

// file: core/dcm_top.sv
// Dual counter/timer block with a classic Wishbone register slave.
// Assumes synchronous external inputs and a single-cycle Wishbone master.
`timescale 1ns/1ps
`include "dcm_defs.svh"
module dcm_top
	import dcm_pkg::*;
#(
	parameter int CW = `DCM_CNT_W,
	parameter logic [15:0] REF_DIV = `DCM_REF_DIV
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [1:0] counter_count_input_i,
	input wire logic [1:0] counter_gate_input_i,
	output logic [1:0] pulse_o,
	output logic [1:0] done_o
);
	logic [10:0] ctrl_r [2];
	logic [10:0] ctrl_nxt [2];
	logic [31:0] load_r [2];
	logic [31:0] load_nxt [2];
	logic [31:0] dat_r, dat_nxt;
	logic ack_r, ack_nxt;
	logic [15:0] div_r, div_nxt;
	logic tick;
	logic [CW-1:0] cnt_w [2];
	logic [CW-1:0] res_w [2];
	logic [CW-1:0] act_w [2];
	logic [1:0] pulse_w;
	logic req;

	// Reference clock tick divider
	assign tick = (div_r == 16'h0000);
	always_comb
	begin
		div_nxt = tick ? REF_DIV - 16'h0001 : div_r - 16'h0001;
	end

	assign req = cyc_i & stb_i & ~ack_r;

	// Register writes and read mux
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		load_nxt = load_r;
		dat_nxt = 32'h0000_0000;
		ack_nxt = req;
		if (req && we_i)
		begin
			if (adr_i == `DCM_CH_CTRL0 && sel_i[0])
				ctrl_nxt[0][7:0] = dat_i[7:0];
			else if (adr_i == `DCM_CH_CTRL1 && sel_i[0])
				ctrl_nxt[1][7:0] = dat_i[7:0];
			else if (adr_i == `DCM_CH_LOAD0)
				load_nxt[0] = dat_i;
			else if (adr_i == `DCM_CH_LOAD1)
				load_nxt[1] = dat_i;
			if (adr_i == `DCM_CH_CTRL0 && sel_i[1])
				ctrl_nxt[0][10:8] = dat_i[10:8];
			else if (adr_i == `DCM_CH_CTRL1 && sel_i[1])
				ctrl_nxt[1][10:8] = dat_i[10:8];
		end
		else if (req)
		begin
			if (adr_i == `DCM_CH_CTRL0)
				dat_nxt = {21'h000000, ctrl_r[0]};
			else if (adr_i == `DCM_CH_CTRL1)
				dat_nxt = {21'h000000, ctrl_r[1]};
			else if (adr_i == `DCM_CH_LOAD0)
				dat_nxt = load_r[0];
			else if (adr_i == `DCM_CH_LOAD1)
				dat_nxt = load_r[1];
			else if (adr_i == `DCM_CH_CNT0)
				dat_nxt = cnt_w[0];
			else if (adr_i == `DCM_CH_CNT1)
				dat_nxt = cnt_w[1];
			else if (adr_i == `DCM_CH_RES0)
				dat_nxt = res_w[0];
			else if (adr_i == `DCM_CH_RES1)
				dat_nxt = res_w[1];
			else if (adr_i == `DCM_CH_HI0)
				dat_nxt = act_w[0];
			else if (adr_i == `DCM_CH_HI1)
				dat_nxt = act_w[1];
		end
	end

	// Register stage of the slave and divider
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r[0] <= 11'h000;
			ctrl_r[1] <= 11'h000;
			load_r[0] <= 32'h0000_0000;
			load_r[1] <= 32'h0000_0000;
			dat_r <= 32'h0000_0000;
			ack_r <= 1'b0;
			div_r <= 16'h0000;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			load_r <= load_nxt;
			dat_r <= dat_nxt;
			ack_r <= ack_nxt;
			div_r <= div_nxt;
		end
	end

	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign pulse_o = pulse_w;

	// Two independent channels; a pulse output may be wired to a gate outside
	for (genvar g = 0; g < 2; g++)
	begin : g_ch
		dcm_channel #(.CW(CW)) u_ch (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.en_i(ctrl_r[g][`DCM_CTRL_EN]),
			.mode_i(dcm_mode_t'(ctrl_r[g][`DCM_CTRL_MODE_LO +: 4])),
			.gate_pol_i(ctrl_r[g][`DCM_CTRL_GPOL]),
			.start_src_i(ctrl_r[g][`DCM_CTRL_START_SRC +: 2]),
			.stop_src_i(ctrl_r[g][`DCM_CTRL_STOP_SRC +: 2]),
			.out_pol_i(ctrl_r[g][`DCM_CTRL_OPOL]),
			.load_i(load_r[g][CW-1:0]),
			.ref_tick_i(tick),
			.count_in_i(counter_count_input_i[g]),
			.gate_in_i(counter_gate_input_i[g]),
			.count_o(cnt_w[g]),
			.result_o(res_w[g]),
			.active_o(act_w[g]),
			.done_o(done_o[g]),
			.pulse_o(pulse_w[g])
		);
	end
endmodule

// file: testbench/dcm_top_monitor.sv
// Port checks on the dual counter/timer top: bus answer and reset.
// Assumes a bind to dcm_top; one clock, synchronous reset.
`timescale 1ns/1ps
module dcm_top_monitor
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [1:0] pulse_o,
	input wire logic [1:0] done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request taken while no answer is pending
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	// Read of a place past the last counter word
	sequence s_hole_rd;
		s_req ##0 (!we_i && adr_i > 8'h24);
	endsequence
	a_ack_follow: assert property (s_req |=> ack_o) else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack no req");
	a_ack_in_req: assert property (ack_o |-> cyc_i && stb_i) else $error("ack alone");
	a_ack_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack idle");
	a_hole_zero: assert property (s_hole_rd |=> dat_o == 32'h0) else $error("hole data");
	a_reset_done: assert property (disable iff (1'b0) rst_i |=> done_o == 2'h0 && !ack_o)
		else $error("done in reset");
	a_reset_pulse: assert property (disable iff (1'b0) rst_i |=> pulse_o == 2'h0)
		else $error("pulse in reset");
endmodule
bind dcm_top dcm_top_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .pulse_o(pulse_o),
	.done_o(done_o));

// file: testbench/dcm_signal_source.sv
// External count-clock and gate sources for both channels.
// Assumes the bench calls burst from its main sequence.
`timescale 1ns/1ps
module dcm_signal_source
(
	input wire logic clk_i,
	output logic [1:0] count_o,
	output logic [1:0] gate_o
);
	// Both lines start low; a gate line keeps the level its last burst or gate pulse set
	initial
	begin
		count_o = 2'h0;
		gate_o = 2'h0;
	end
	// Gate level first, then n edges two clocks high and low
	task automatic burst(input int ch, input logic g, input int n);
		@(posedge clk_i);
		gate_o[ch] <= g;
		repeat (n)
		begin
			repeat (2) @(posedge clk_i);
			count_o[ch] <= 1'b1;
			repeat (2) @(posedge clk_i);
			count_o[ch] <= 1'b0;
		end
		repeat (3) @(posedge clk_i);
	endtask
	// Gate high for hi clocks, then low for lo clocks, from this edge
	task automatic gate_pulse(input int ch, input int hi, input int lo);
		gate_o[ch] <= 1'b1;
		repeat (hi) @(posedge clk_i);
		gate_o[ch] <= 1'b0;
		repeat (lo) @(posedge clk_i);
	endtask
endmodule

// file: testbench/dcm_top_tb.sv
// Self-checking bench for the dual counter/timer top.
// Assumes the signal source model and the port monitor.
`timescale 1ns/1ps
module dcm_top_tb;
	logic clk, rst, cyc, stb, we, ack;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, bus_rd;
	logic [1:0] cnt, gate, pulse, done;
	int num_errors, cmp_count;
	logic [15:0] seq;
	dcm_signal_source src (.clk_i(clk), .count_o(cnt), .gate_o(gate));
	dcm_top uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hF), .dat_i(wdat), .dat_o(bus_rd), .ack_o(ack),
		.counter_count_input_i(cnt), .counter_gate_input_i(gate), .pulse_o(pulse),
		.done_o(done));
	// Free-running 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task close_out;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One classic cycle, held until ack, bounded wait
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (ack !== 1'b1 && i < 50);
		rdat = bus_rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			num_errors++;
			$display("wrong value at %0t: no ack", $time);
			close_out();
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask
	// Sixteen edges of one pulse output, oldest sample first
	task sample(input int ch, output logic [15:0] v);
		v = 16'h0000;
		repeat (16)
		begin
			@(posedge clk);
			v = {v[14:0], pulse[ch]};
		end
	endtask
	// Reset, then the counting scenarios
	initial
	begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		wdat = 32'h0;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		wb(1'b1, 8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		wb(1'b1, 8'h00, 32'h22);
		wb(1'b1, 8'h00, 32'h23);
		src.burst(0, 1'b1, 4);
		src.burst(0, 1'b0, 3);
		rd(8'h10, 32'h4);
		wb(1'b1, 8'h00, 32'h02);
		wb(1'b1, 8'h00, 32'h03);
		src.burst(0, 1'b1, 2);
		src.burst(0, 1'b0, 5);
		rd(8'h10, 32'h5);
		wb(1'b1, 8'h04, 32'h04);
		wb(1'b1, 8'h04, 32'h05);
		src.burst(1, 1'b0, 3);
		src.burst(1, 1'b1, 2);
		rd(8'h14, 32'h5);
		rd(8'h10, 32'h5);
		wb(1'b1, 8'h00, 32'h06);
		wb(1'b1, 8'h00, 32'h07);
		src.burst(0, 1'b1, 5);
		src.burst(0, 1'b0, 2);
		rd(8'h10, 32'h3);
		src.burst(0, 1'b0, 4);
		rd(8'h10, 32'hFFFFFFFF);
		wb(1'b1, 8'h00, 32'h06);
		wb(1'b1, 8'h00, 32'h07);
		rd(8'h10, 32'h0);
		// Period and active time on channel 1, gate active high
		src.burst(1, 1'b0, 0);
		wb(1'b1, 8'h04, 32'h2A);
		wb(1'b1, 8'h04, 32'h2B);
		src.gate_pulse(1, 3, 5);
		src.gate_pulse(1, 3, 5);
		rd(8'h1C, 32'h8);
		rd(8'h24, 32'h3);
		check({30'h0, done}, 32'h2);
		// One-shot, then repetitive one-shot, high for load plus one ticks
		wb(1'b1, 8'h0C, 32'h1);
		wb(1'b1, 8'h04, 32'h32);
		wb(1'b1, 8'h04, 32'h33);
		fork
			src.gate_pulse(1, 2, 6);
			sample(1, seq);
		join
		check({16'h0, seq}, 32'h6000);
		check({30'h0, done}, 32'h2);
		wb(1'b1, 8'h04, 32'h34);
		wb(1'b1, 8'h04, 32'h35);
		fork
			begin
				src.gate_pulse(1, 2, 3);
				src.gate_pulse(1, 2, 3);
			end
			sample(1, seq);
		join
		check({16'h0, seq}, 32'h6300);
		check({30'h0, done}, 32'h0);
		// Rate output on channel 0, inverted, toggling every load plus one ticks
		wb(1'b1, 8'h08, 32'h2);
		wb(1'b1, 8'h00, 32'h410);
		wb(1'b1, 8'h00, 32'h411);
		sample(0, seq);
		check({16'h0, seq}, 32'hE38E);
		// Frequency: edges counted while the gate is active
		wb(1'b1, 8'h00, 32'h28);
		wb(1'b1, 8'h00, 32'h29);
		src.burst(0, 1'b1, 3);
		src.burst(0, 1'b0, 2);
		rd(8'h18, 32'h3);
		check({30'h0, done}, 32'h1);
		// Edge to edge: count-clock rise starts, gate fall stops
		wb(1'b1, 8'h00, 32'h30C);
		wb(1'b1, 8'h00, 32'h30D);
		src.burst(0, 1'b1, 1);
		src.burst(0, 1'b0, 0);
		rd(8'h18, 32'h6);
		check({30'h0, done}, 32'h1);
		// Continuous edge to edge on channel 1, rises four clocks apart
		wb(1'b1, 8'h04, 32'h0E);
		wb(1'b1, 8'h04, 32'h0F);
		src.burst(1, 1'b0, 3);
		rd(8'h1C, 32'h4);
		close_out();
	end
endmodule
